// *** verilog/nvc_pkg.sv ***
// Shared constants, types and pin bundles for the nonvolatile SRAM host controller.
// Assumes a single 10 MHz system clock; all times below are converted to cycles of it.
package nvc_pkg;

    localparam int CLK_NS       = 100;
    localparam int AW           = 15;
    localparam int DW           = 8;
    localparam int CNT_W        = 24;
    localparam int SYNC_LAT     = 3;

    // Device times in their printed units.
    localparam int ACCESS_NS    = 45;
    localparam int RECALL_US    = 20;
    localparam int STORE_MS     = 10;
    localparam int PWRUP_US     = 650;
    localparam int HSB_W_NS     = 20;
    localparam int HSB_DIS_NS   = 500;

    // Host waits cover the device maxima, so every figure rounds up.
    localparam int ACC_CYC      = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC   = ACC_CYC + SYNC_LAT;
    localparam int RECALL_CYC   = (RECALL_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int STORE_CYC    = (STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int PWRUP_CYC    = (PWRUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int HSB_PULSE    = (HSB_W_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int HSB_DIS_CYC  = (HSB_DIS_NS + CLK_NS - 1) / CLK_NS;

    // Unlock sequence addresses.
    localparam logic [AW-1:0] SEQ_A0     = 15'h0e38;
    localparam logic [AW-1:0] SEQ_A1     = 15'h31c7;
    localparam logic [AW-1:0] SEQ_A2     = 15'h03e0;
    localparam logic [AW-1:0] SEQ_A3     = 15'h3c1f;
    localparam logic [AW-1:0] SEQ_A4     = 15'h303f;
    localparam logic [AW-1:0] SEQ_STORE  = 15'h0fc0;
    localparam logic [AW-1:0] SEQ_RECALL = 15'h0c63;
    localparam logic [2:0]    SEQ_LAST   = 3'h5;

    typedef enum logic [2:0] {
        NVC_CMD_READ,
        NVC_CMD_WRITE,
        NVC_CMD_STORE,
        NVC_CMD_RECALL,
        NVC_CMD_HWSTORE
    } nvc_cmd_t;

    typedef struct packed {
        nvc_cmd_t         cmd;
        logic [AW-1:0]    addr;
        logic [DW-1:0]    wdata;
    } nvc_req_t;

    typedef struct packed {
        logic [AW-1:0]    addr;
        logic             chip_sel_n;
        logic             out_en_n;
        logic             wr_en_n;
        logic [DW-1:0]    dq;
        logic             dq_oe;
        logic             busy;
        logic             busy_oe;
    } nvc_pins_t;

    // Address of sequence step idx; the sixth picks store or recall.
    function automatic logic [AW-1:0] seq_addr(input logic [2:0] idx, input logic recall);
        logic [AW-1:0] a;
        a = SEQ_A0;
        case (idx)
            3'h1:    a = SEQ_A1;
            3'h2:    a = SEQ_A2;
            3'h3:    a = SEQ_A3;
            3'h4:    a = SEQ_A4;
            3'h5:    a = recall ? SEQ_RECALL : SEQ_STORE;
            default: a = SEQ_A0;
        endcase
        return a;
    endfunction : seq_addr

endpackage : nvc_pkg

// *** verilog/nvc_host.sv ***
// Host controller that drives a 32K x 8 nonvolatile SRAM over its asynchronous pins.
// Assumes the bidirectional data bus and open-drain busy line are resolved outside.
// Function
// - Host holds address stable for the whole write.
// - Host gives each sequence address its own chip-select pulse.
// - Host keeps write enable high while chip select is low in a sequence.
// - Host keeps write enable inactive as power-up recall finishes.
// - Sequence is 0E38 31C7 03E0 3C1F 303F then 0FC0 or 0C63.
`timescale 1ns/10ps
`default_nettype none

module nvc_host
    import nvc_pkg::*;
#(
    parameter int STORE_WAIT = STORE_CYC,
    parameter int PWRUP_WAIT = PWRUP_CYC
)(
    input  wire logic          sys_clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          req_valid_i,
    input  wire nvc_req_t      req_i,
    output var  logic          req_ready_o,
    output var  logic          rsp_valid_o,
    output var  logic [DW-1:0] rsp_rdata_o,
    output var  nvc_pins_t     pins_o,
    input  wire logic [DW-1:0] data_i,
    input  wire logic          store_busy_line_n_i
);

    if (STORE_WAIT < 1 || STORE_WAIT >= (1 << CNT_W) || PWRUP_WAIT < 1 || PWRUP_WAIT >= (1 << CNT_W))
    begin : g_bad_param
        $error("nvc_host: wait parameters out of range");
    end

    typedef enum logic [3:0] {
        S_PWRUP, S_BUSYWAIT, S_IDLE, S_SETUP, S_STROBE, S_END, S_NVWAIT, S_HSBPULSE, S_HSBWAIT
    } nvc_state_t;

    localparam nvc_pins_t PINS_IDLE = '{addr: '0, chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1,
                                        dq: '0, dq_oe: 1'b0, busy: 1'b0, busy_oe: 1'b0};

    nvc_state_t       state_q, state_d;
    nvc_cmd_t         op_q, op_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [2:0]       step_q, step_d;
    nvc_pins_t        pins_q, pins_d;
    logic             ready_q, ready_d;
    logic             rsp_q, rsp_d;
    logic [DW-1:0]    rdata_q, rdata_d;
    logic [DW:0]      s1_q, s2_q, s3_q, filt_q, filt_d;
    logic             busy_f;
    logic             is_seq;

    // Three-stage synchroniser; a bit counts only once stages two and three agree.
    always_comb
    begin
        filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s1_q   <= {1'b1, {DW{1'b0}}};
            s2_q   <= {1'b1, {DW{1'b0}}};
            s3_q   <= {1'b1, {DW{1'b0}}};
            filt_q <= {1'b1, {DW{1'b0}}};
        end
        else
        begin
            s1_q   <= {store_busy_line_n_i, data_i};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    assign busy_f = filt_q[DW];
    assign is_seq = (op_q == NVC_CMD_STORE) || (op_q == NVC_CMD_RECALL);

    // Access sequencer; every pin change is planned here and registered below.
    always_comb
    begin
        state_d = state_q;
        op_d    = op_q;
        cnt_d   = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
        step_d  = step_q;
        pins_d  = pins_q;
        ready_d = 1'b0;
        rsp_d   = 1'b0;
        rdata_d = rdata_q;
        case (state_q)
            S_PWRUP:
            begin
                // Controls stay high so no write is open when the recall ends.
                pins_d = PINS_IDLE;
                if (cnt_q == '0)
                    state_d = S_BUSYWAIT;
            end
            S_BUSYWAIT:
            begin
                // A store in progress holds the line low; access resumes once it rises.
                if (busy_f)
                    state_d = S_IDLE;
            end
            S_IDLE:
            begin
                ready_d = busy_f;
                if (req_valid_i && ready_q)
                begin
                    ready_d = 1'b0;
                    op_d    = req_i.cmd;
                    step_d  = '0;
                    case (req_i.cmd)
                        NVC_CMD_READ, NVC_CMD_WRITE:
                        begin
                            pins_d.addr  = req_i.addr;
                            pins_d.dq    = req_i.wdata;
                            pins_d.dq_oe = (req_i.cmd == NVC_CMD_WRITE);
                            state_d      = S_SETUP;
                        end
                        NVC_CMD_STORE, NVC_CMD_RECALL:
                        begin
                            pins_d.addr = seq_addr(3'h0, req_i.cmd == NVC_CMD_RECALL);
                            state_d     = S_SETUP;
                        end
                        default:
                        begin
                            pins_d.busy_oe = 1'b1;
                            cnt_d          = CNT_W'(HSB_PULSE - 1);
                            state_d        = S_HSBPULSE;
                        end
                    endcase
                end
            end
            S_SETUP:
            begin
                // Address already settled a cycle earlier, so it is stable before the strobe.
                pins_d.chip_sel_n = 1'b0;
                pins_d.wr_en_n    = (op_q != NVC_CMD_WRITE);
                pins_d.out_en_n   = (op_q == NVC_CMD_WRITE);
                cnt_d             = CNT_W'(STROBE_CYC - 1);
                state_d           = S_STROBE;
            end
            S_STROBE:
            begin
                if (cnt_q == '0)
                begin
                    // Strobe covers the access time; the filter settles on the byte one cycle later.
                    pins_d.chip_sel_n = 1'b1;
                    pins_d.wr_en_n    = 1'b1;
                    pins_d.out_en_n   = 1'b1;
                    state_d           = S_END;
                end
            end
            S_END:
            begin
                // Address and data are held this cycle; the filter now carries the strobed byte.
                rdata_d      = filt_q[DW-1:0];
                pins_d.dq_oe = 1'b0;
                if (is_seq && step_q != SEQ_LAST)
                begin
                    step_d      = step_q + 3'h1;
                    pins_d.addr = seq_addr(step_q + 3'h1, op_q == NVC_CMD_RECALL);
                    state_d     = S_SETUP;
                end
                else if (is_seq)
                begin
                    cnt_d   = (op_q == NVC_CMD_STORE) ? CNT_W'(STORE_WAIT - 1) : CNT_W'(RECALL_CYC - 1);
                    state_d = S_NVWAIT;
                end
                else
                begin
                    rsp_d   = 1'b1;
                    state_d = S_BUSYWAIT;
                end
            end
            S_NVWAIT:
            begin
                if (cnt_q == '0)
                begin
                    rsp_d   = 1'b1;
                    state_d = S_BUSYWAIT;
                end
            end
            S_HSBPULSE:
            begin
                // Pulse is one cycle longer than the minimum so it is surely seen.
                if (cnt_q == '0)
                begin
                    pins_d.busy_oe = 1'b0;
                    cnt_d          = CNT_W'(HSB_DIS_CYC + SYNC_LAT);
                    state_d        = S_HSBWAIT;
                end
            end
            S_HSBWAIT:
            begin
                // Give the device time to take the line itself before watching it.
                if (cnt_q == '0)
                begin
                    rsp_d   = 1'b1;
                    state_d = S_BUSYWAIT;
                end
            end
            default:
            begin
                state_d = S_BUSYWAIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= S_PWRUP;
            op_q    <= NVC_CMD_READ;
            cnt_q   <= CNT_W'(PWRUP_WAIT - 1);
            step_q  <= '0;
            pins_q  <= PINS_IDLE;
            ready_q <= 1'b0;
            rsp_q   <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            op_q    <= op_d;
            cnt_q   <= cnt_d;
            step_q  <= step_d;
            pins_q  <= pins_d;
            ready_q <= ready_d;
            rsp_q   <= rsp_d;
            rdata_q <= rdata_d;
        end
    end

    assign req_ready_o = ready_q;
    assign rsp_valid_o = rsp_q;
    assign rsp_rdata_o = rdata_q;
    assign pins_o      = pins_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_strobe_open;
        $fell(pins_q.chip_sel_n);
    endsequence

    sequence s_strobe_held;
        !pins_q.chip_sel_n [*4];
    endsequence

    chk_addr_stable: assert property ((!pins_q.chip_sel_n && $past(!pins_q.chip_sel_n)) |-> $stable(pins_q.addr))
        else $error("address moved during a strobe");
    chk_addr_hold: assert property ($rose(pins_q.chip_sel_n) |-> $stable(pins_q.addr))
        else $error("address changed as the strobe ended");
    chk_seq_pulse: assert property ($changed(step_q) |-> pins_q.chip_sel_n ##1 s_strobe_open)
        else $error("sequence step without its own strobe");
    chk_seq_we_high: assert property ((is_seq && !pins_q.chip_sel_n) |-> pins_q.wr_en_n)
        else $error("write enable low during sequence");
    chk_pwrup_quiet: assert property ((state_q == S_PWRUP) |-> (pins_q.wr_en_n && pins_q.chip_sel_n))
        else $error("write state during power-up recall");
    chk_seq_addr_list: assert property ((is_seq && !pins_q.chip_sel_n) |-> pins_q.addr == seq_addr(step_q, op_q == NVC_CMD_RECALL))
        else $error("wrong sequence address");
    chk_strobe_width: assert property (s_strobe_open |-> s_strobe_held ##1 pins_q.chip_sel_n)
        else $error("strobe width not four cycles");

endmodule : nvc_host

`default_nettype wire

// *** tb/nvc_dev_model.sv ***
// Behavioural nonvolatile SRAM that answers the host controller's pins.
// Assumes the bench ties its outputs to the controller's data and busy inputs.
`timescale 1ns/10ps
`default_nettype none

module nvc_dev_model
    import nvc_pkg::*;
#(
    parameter int STORE_NS  = 3000,
    parameter int RECALL_NS = 2000,
    parameter int DIS_NS    = 500
)(
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          ce_n_i,
    input  wire logic          oe_n_i,
    input  wire logic          we_n_i,
    input  wire logic [DW-1:0] host_dq_i,
    input  wire logic          host_dq_oe_i,
    input  wire logic          host_busy_oe_i,
    input  wire logic          ext_busy_i,
    input  wire logic          supply_low_i,
    output logic      [DW-1:0] dq_o,
    output logic               busy_n_o
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] nv  [0:(1<<AW)-1];
    logic [AW-1:0] seq_tbl [0:4] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic [DW-1:0] last_q   = 8'h00;
    logic          dev_pull = 1'b0;
    logic          nv_op    = 1'b0;
    logic          dirty    = 1'b0;
    logic          recall_req = 1'b0;
    bit            live     = 1'b0;
    int            step     = 0;
    int            n_store  = 0;
    int            n_recall = 0;
    wire           rd_act   = !ce_n_i && !oe_n_i && we_n_i && busy_n_o && !nv_op && !supply_low_i;
    wire           wr_act   = !ce_n_i && !we_n_i && busy_n_o && !nv_op && !supply_low_i;

    // Store erases and programs every cell at once while all pins are ignored.
    task automatic do_store();
        nv_op = 1'b1;
        dev_pull = 1'b1;
        #(STORE_NS);
        nv = mem;
        dirty = 1'b0;
        step = 0;
        n_store++;
        dev_pull = 1'b0;
        nv_op = 1'b0;
    endtask : do_store

    // Recall reloads the array; pins stay ignored until it is done.
    task automatic do_recall();
        nv_op = 1'b1;
        #(RECALL_NS);
        mem = nv;
        step = 0;
        n_recall++;
        nv_op = 1'b0;
    endtask : do_recall

    // Edges seen before time zero settles are not real accesses.
    initial #1 live = 1'b1;

    // Open-drain busy line with a pull-up: low while anyone pulls it.
    assign busy_n_o = !(host_busy_oe_i || ext_busy_i || dev_pull);
    // A released bus shows the inverse of its last value, so stale data never passes.
    assign dq_o = host_dq_oe_i ? host_dq_i : (rd_act ? mem[addr_i] : ~last_q);

    always @(negedge rd_act) last_q = mem[addr_i];
    always @(negedge host_dq_oe_i) last_q = host_dq_i;

    // A write lands when its strobe ends and disarms any half-entered sequence.
    always @(negedge wr_act)
    begin
        if (live)
        begin
            mem[addr_i] = host_dq_i;
            dirty = 1'b1;
            step = 0;
        end
    end

    // A chip-select fall with write high, busy high and no store or recall running is one step of the unlock sequence.
    always @(negedge ce_n_i)
    begin
        if (live && we_n_i && busy_n_o && !nv_op)
        begin
            if (step == 5 && addr_i == SEQ_STORE)
                do_store();
            else if (step == 5 && addr_i == SEQ_RECALL)
                do_recall();
            else if (step < 5 && addr_i == seq_tbl[step])
                step++;
            else
                step = (addr_i == SEQ_A0) ? 1 : 0;
        end
    end

    // Supply loss: the capacitor carries one store if anything changed, and a recall waits for power.
    always @(posedge supply_low_i)
    begin
        recall_req = 1'b1;
        if (dirty)
            do_store();
    end

    // Power back: the latched recall runs before any access is served.
    always @(negedge supply_low_i)
    begin
        if (recall_req)
        begin
            recall_req = 1'b0;
            do_recall();
        end
    end

    // Another party pulled the busy line: store after the disable delay if dirty.
    always @(negedge busy_n_o)
    begin
        if (live && !dev_pull)
        begin
            #(DIS_NS);
            if (dirty)
                do_store();
        end
    end

endmodule : nvc_dev_model

`default_nettype wire

// *** tb/nvc_host_bench.sv ***
// Self-checking bench for the nonvolatile SRAM host controller.
// Assumes the device model file is compiled first; counts are shortened by parameters.
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

module nvc_host_bench
    import nvc_pkg::*;
;

    logic          sys_clk_i   = 1'b0;
    logic          sys_rst_i   = 1'b1;
    logic          req_valid_i = 1'b0;
    nvc_req_t      req_i       = '0;
    logic          ext_busy    = 1'b0;
    logic          supply_low  = 1'b0;
    logic          req_ready_o;
    logic          rsp_valid_o;
    logic [DW-1:0] rsp_rdata_o;
    nvc_pins_t     pins_o;
    logic [DW-1:0] dev_dq;
    logic          busy_n;
    int            n_fail      = 0;
    int            tests_run   = 0;

    // A 100 ns clock; store wait is shortened but still outlasts the model's store.
    always #50 sys_clk_i = ~sys_clk_i;

    nvc_host #(.STORE_WAIT(50), .PWRUP_WAIT(20)) dut_u (
        .sys_clk_i           (sys_clk_i),
        .sys_rst_i           (sys_rst_i),
        .req_valid_i         (req_valid_i),
        .req_i               (req_i),
        .req_ready_o         (req_ready_o),
        .rsp_valid_o         (rsp_valid_o),
        .rsp_rdata_o         (rsp_rdata_o),
        .pins_o              (pins_o),
        .data_i              (dev_dq),
        .store_busy_line_n_i (busy_n)
    );

    nvc_dev_model #(.STORE_NS(3000), .RECALL_NS(2000), .DIS_NS(HSB_DIS_NS)) dev_u (
        .addr_i         (pins_o.addr),
        .ce_n_i         (pins_o.chip_sel_n),
        .oe_n_i         (pins_o.out_en_n),
        .we_n_i         (pins_o.wr_en_n),
        .host_dq_i      (pins_o.dq),
        .host_dq_oe_i   (pins_o.dq_oe),
        .host_busy_oe_i (pins_o.busy_oe),
        .ext_busy_i     (ext_busy),
        .supply_low_i   (supply_low),
        .dq_o           (dev_dq),
        .busy_n_o       (busy_n)
    );

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // Holds the request until it is taken, then waits for the one-cycle answer.
    task automatic req_do(input nvc_cmd_t cmd, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int n;
        n = 0;
        req_i <= '{cmd, a, d};
        req_valid_i <= 1'b1;
        do @(posedge sys_clk_i); while (req_ready_o !== 1'b1 && ++n < 400);
        req_valid_i <= 1'b0;
        n = 0;
        do @(posedge sys_clk_i); while (rsp_valid_o !== 1'b1 && ++n < 800);
        `CHK(rsp_valid_o, 1'b1)
    endtask : req_do

    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        req_do(NVC_CMD_READ, a, 8'h00);
        `CHK(rsp_rdata_o, e)
    endtask : rd_chk

    task automatic t_reset_state();
        `CHK({pins_o.chip_sel_n, pins_o.dq_oe, pins_o.busy_oe, req_ready_o}, 4'h8)
    endtask : t_reset_state

    // Both ends of the address range, read back after back-to-back writes.
    task automatic t_rw();
        req_do(NVC_CMD_WRITE, 15'h7fff, 8'ha5);
        req_do(NVC_CMD_WRITE, 15'h0000, 8'h5a);
        `CHK(dev_u.mem[15'h7fff], 8'ha5)
        rd_chk(15'h7fff, 8'ha5);
        rd_chk(15'h0000, 8'h5a);
    endtask : t_rw

    // Store, overwrite, recall: the old byte must return; a clean store still runs.
    task automatic t_sw_store_recall();
        req_do(NVC_CMD_WRITE, 15'h0010, 8'h33);
        req_do(NVC_CMD_STORE, 15'h0000, 8'h00);
        `CHK(dev_u.n_store, 1)
        req_do(NVC_CMD_WRITE, 15'h0010, 8'h44);
        req_do(NVC_CMD_RECALL, 15'h0000, 8'h00);
        `CHK({dev_u.n_recall, dev_u.n_store}, {32'd1, 32'd1})
        rd_chk(15'h0010, 8'h33);
        req_do(NVC_CMD_STORE, 15'h0000, 8'h00);
        `CHK(dev_u.n_store, 2)
    endtask : t_sw_store_recall

    // Busy-line store after a write runs; a second one with nothing new is skipped.
    task automatic t_hw_store();
        req_do(NVC_CMD_WRITE, 15'h0020, 8'h77);
        req_do(NVC_CMD_HWSTORE, 15'h0000, 8'h00);
        req_do(NVC_CMD_READ, 15'h0000, 8'h00);
        `CHK(dev_u.n_store, 3)
        req_do(NVC_CMD_HWSTORE, 15'h0000, 8'h00);
        rd_chk(15'h0020, 8'h77);
        `CHK(dev_u.n_store, 3)
    endtask : t_hw_store

    // A busy line held low from outside must stop the controller taking work.
    task automatic t_ext_busy();
        ext_busy <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        `CHK(req_ready_o, 1'b0)
        ext_busy <= 1'b0;
        rd_chk(15'h0020, 8'h77);
        `CHK(dev_u.n_store, 3)
    endtask : t_ext_busy

    // Supply loss with a host reset: the dirty byte is stored, then recalled once power returns.
    task automatic t_power_cycle();
        req_do(NVC_CMD_WRITE, 15'h0030, 8'h6c);
        supply_low <= 1'b1;
        sys_rst_i  <= 1'b1;
        repeat (40) @(posedge sys_clk_i);
        `CHK(req_ready_o, 1'b0)
        `CHK(dev_u.n_store, 4)
        `CHK(dev_u.nv[15'h0030], 8'h6c)
        supply_low <= 1'b0;
        sys_rst_i  <= 1'b0;
        rd_chk(15'h0030, 8'h6c);
        `CHK(dev_u.n_recall, 2)
    endtask : t_power_cycle

    // Cuts a hang short; the whole run needs well under a thousand cycles.
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        n_fail++;
        print_verdict();
    end

    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        t_reset_state();
        sys_rst_i <= 1'b0;
        t_rw();
        t_sw_store_recall();
        t_hw_store();
        t_ext_busy();
        t_power_cycle();
        print_verdict();
    end

endmodule : nvc_host_bench

`default_nettype wire
